/* verilog/ddrca_top.sv */
// Command, address and control pin logic of a double-data-rate memory device.
`timescale 1ns/1ns
`default_nettype none
module ddrca_top #(
   parameter int ROW_BITS = ddrca_pkg::ROW_BITS,
   parameter int BANK_BITS = ddrca_pkg::BANK_BITS,
   parameter bit EIGHT_BIT_WIDE = 1'b1
) (
   // Core clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Link clock from the controller
   input wire logic cmd_clock,
   // Command strobes
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   // Address and bank
   input wire logic [ROW_BITS-1:0] address,
   input wire logic [BANK_BITS-1:0] bank_select,
   // Control pins
   input wire logic clock_gate,
   input wire logic termination_enable,
   input wire logic write_mask,
   input wire logic write_beat_valid,
   // Link-side status
   output ddrca_pkg::ddrca_pwr_t power_state,
   output logic [(1<<BANK_BITS)-1:0] banks_open,
   output logic termination_on,
   output logic termination_data_strobe_on,
   output logic write_beat_keep,
   // Core-side command delivery
   output logic cmd_valid,
   output ddrca_pkg::ddrca_cmd_t cmd_code,
   output logic [BANK_BITS-1:0] cmd_bank,
   output logic [ROW_BITS-1:0] cmd_addr,
   output logic cmd_auto_precharge,
   output logic cmd_all_banks,
   output logic cmd_burst_chop,
   output logic self_refresh_exit
);
   generate
      if (ROW_BITS <= ddrca_pkg::BURST_CHOP_BIT || ROW_BITS <= ddrca_pkg::TERM_STROBE_BIT) begin : g_bad_row
         $error("ddrca_top: address too narrow for chop and mode fields");
      end
      if (BANK_BITS < ddrca_pkg::MODE_INDEX_BITS) begin : g_bad_bank
         $error("ddrca_top: bank select too narrow to pick a mode register");
      end
   endgenerate

   // Link domain: pins registered on the rising link clock.
   logic cs_n_q;
   logic ras_n_q;
   logic cas_n_q;
   logic we_n_q;
   logic [ROW_BITS-1:0] addr_q;
   logic [BANK_BITS-1:0] ba_q;
   logic cke_q;
   logic odt_q;
   logic mask_q;
   logic beat_q;
   // Link domain state.
   logic [ROW_BITS-1:0] mode_regs [ddrca_pkg::MODE_REG_COUNT];
   ddrca_pkg::ddrca_pwr_t next_power_state;
   ddrca_pkg::ddrca_cmd_t raw_cmd;
   ddrca_pkg::ddrca_cmd_t live_cmd;
   logic mode_index_ok;
   logic [ddrca_pkg::MODE_INDEX_BITS-1:0] mode_index;
   logic term_strobe_mode;
   logic term_allowed;
   logic [1:0] burst_field;
   // Words held for the core domain until the next command.
   ddrca_pkg::ddrca_cmd_t held_cmd;
   logic [BANK_BITS-1:0] held_bank;
   logic [ROW_BITS-1:0] held_addr;
   logic held_ap;
   logic held_all;
   logic held_chop;
   logic held_toggle;
   logic in_self_refresh;
   // Crossings.
   ddrca_sync_if toggle_x ();
   ddrca_sync_if gate_x ();
   ddrca_sync_if refresh_x ();
   ddrca_sync_if exit_x ();
   // Core domain state.
   logic toggle_seen;
   logic toggle_event;

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         cs_n_q <= 1'b1;
         ras_n_q <= 1'b1;
         cas_n_q <= 1'b1;
         we_n_q <= 1'b1;
         addr_q <= '0;
         ba_q <= '0;
         cke_q <= 1'b1;
         odt_q <= 1'b0;
         mask_q <= 1'b0;
         beat_q <= 1'b0;
      end else begin
         cs_n_q <= chip_select_n;
         ras_n_q <= row_strobe_n;
         cas_n_q <= column_strobe_n;
         we_n_q <= write_enable_n;
         addr_q <= address;
         ba_q <= bank_select;
         cke_q <= clock_gate;
         odt_q <= termination_enable;
         mask_q <= write_mask;
         beat_q <= write_beat_valid;
      end
   end

   assign raw_cmd = ddrca_pkg::decode(cs_n_q, ras_n_q, cas_n_q, we_n_q);
   // Except for self refresh entry, commands act only when the device is awake and the gate stays high.
   always_comb begin
      live_cmd = ddrca_pkg::CMD_NOP;
      if (raw_cmd == ddrca_pkg::CMD_DESELECT) begin
         live_cmd = ddrca_pkg::CMD_NOP;
      end else if (power_state == ddrca_pkg::PWR_ACTIVE && cke_q) begin
         live_cmd = raw_cmd;
      end
   end

   assign mode_index = ba_q[ddrca_pkg::MODE_INDEX_BITS-1:0];
   // Bank select codes above the last mode register are not loaded.
   assign mode_index_ok = ba_q < BANK_BITS'(ddrca_pkg::MODE_REG_COUNT);
   assign burst_field = mode_regs[ddrca_pkg::MODE_BURST_REG][ddrca_pkg::BURST_FIELD_LSB +: 2];
   assign term_strobe_mode = EIGHT_BIT_WIDE && mode_regs[ddrca_pkg::MODE_TERM_REG][ddrca_pkg::TERM_STROBE_BIT];
   assign term_allowed = mode_regs[ddrca_pkg::MODE_TERM_REG][ddrca_pkg::TERM_VALUE_BIT0]
                       | mode_regs[ddrca_pkg::MODE_TERM_REG][ddrca_pkg::TERM_VALUE_BIT1]
                       | mode_regs[ddrca_pkg::MODE_TERM_REG][ddrca_pkg::TERM_VALUE_BIT2];

   always_comb begin
      next_power_state = power_state;
      unique case (power_state)
         ddrca_pkg::PWR_ACTIVE: begin
            if (!cke_q) begin
               if (raw_cmd == ddrca_pkg::CMD_REFRESH) begin
                  next_power_state = ddrca_pkg::PWR_SELF_REFRESH;
               end else if (|banks_open) begin
                  next_power_state = ddrca_pkg::PWR_ACTIVE_DOWN;
               end else begin
                  next_power_state = ddrca_pkg::PWR_PRECHARGE_DOWN;
               end
            end
         end
         ddrca_pkg::PWR_PRECHARGE_DOWN,
         ddrca_pkg::PWR_ACTIVE_DOWN: begin
            if (cke_q) begin
               next_power_state = ddrca_pkg::PWR_ACTIVE;
            end
         end
         ddrca_pkg::PWR_SELF_REFRESH: begin
            if (exit_x.q) begin
               next_power_state = ddrca_pkg::PWR_ACTIVE;
            end
         end
      endcase
   end

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         power_state <= ddrca_pkg::PWR_ACTIVE;
      end else begin
         power_state <= next_power_state;
      end
   end
   assign in_self_refresh = power_state == ddrca_pkg::PWR_SELF_REFRESH;
   assign refresh_x.d = in_self_refresh;

   // Row tracking per bank.
   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         banks_open <= '0;
      end else begin
         unique case (live_cmd)
            ddrca_pkg::CMD_ACTIVATE: banks_open[ba_q] <= 1'b1;
            ddrca_pkg::CMD_PRECHARGE: begin
               if (addr_q[ddrca_pkg::AUTO_PRECHARGE_BIT]) begin
                  banks_open <= '0;
               end else begin
                  banks_open[ba_q] <= 1'b0;
               end
            end
            ddrca_pkg::CMD_READ,
            ddrca_pkg::CMD_WRITE: begin
               if (addr_q[ddrca_pkg::AUTO_PRECHARGE_BIT]) begin
                  banks_open[ba_q] <= 1'b0;
               end
            end
            default: banks_open <= banks_open;
         endcase
      end
   end

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < ddrca_pkg::MODE_REG_COUNT; i++) begin
            mode_regs[i] <= '0;
         end
      end else if (live_cmd == ddrca_pkg::CMD_LOAD_MODE && mode_index_ok) begin
         mode_regs[mode_index] <= addr_q;
      end
   end

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         termination_on <= 1'b0;
      end else begin
         termination_on <= term_allowed && odt_q && !in_self_refresh;
      end
   end

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         termination_data_strobe_on <= 1'b0;
      end else begin
         termination_data_strobe_on <= term_strobe_mode;
      end
   end

   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         write_beat_keep <= 1'b0;
      end else begin
         write_beat_keep <= beat_q && power_state == ddrca_pkg::PWR_ACTIVE && (term_strobe_mode || !mask_q);
      end
   end

   // The held word stays still until the next command, so the core can
   // sample it after seeing the toggle without a second handshake.
   always_ff @(posedge cmd_clock or negedge nrst) begin
      if (!nrst) begin
         held_cmd <= ddrca_pkg::CMD_NOP;
         held_bank <= '0;
         held_addr <= '0;
         held_ap <= 1'b0;
         held_all <= 1'b0;
         held_chop <= 1'b0;
         held_toggle <= 1'b0;
      end else if (live_cmd != ddrca_pkg::CMD_NOP) begin
         held_cmd <= live_cmd;
         held_bank <= ba_q;
         held_ap <= 1'b0;
         held_all <= 1'b0;
         held_chop <= 1'b0;
         held_addr <= addr_q;
         held_toggle <= ~held_toggle;
         if (live_cmd == ddrca_pkg::CMD_READ || live_cmd == ddrca_pkg::CMD_WRITE) begin
            held_addr <= ROW_BITS'(addr_q[ddrca_pkg::COLUMN_BITS-1:0]);
            held_ap <= addr_q[ddrca_pkg::AUTO_PRECHARGE_BIT];
            held_chop <= ddrca_pkg::chop_of(burst_field, addr_q[ddrca_pkg::BURST_CHOP_BIT]);
         end
         if (live_cmd == ddrca_pkg::CMD_PRECHARGE) begin
            held_all <= addr_q[ddrca_pkg::AUTO_PRECHARGE_BIT];
         end
      end
   end

   assign toggle_x.d = held_toggle;
   assign gate_x.d = clock_gate;

   // Link-side synchroniser of the core's self refresh exit request.
   ddrca_sync u_exit_sync (.clock(cmd_clock), .nrst(nrst), .port(exit_x.sync_side));
   // Core-side synchronisers.
   ddrca_sync u_toggle_sync (.clock(clock), .nrst(nrst), .port(toggle_x.sync_side));
   ddrca_sync u_gate_sync (.clock(clock), .nrst(nrst), .port(gate_x.sync_side));
   ddrca_sync u_refresh_sync (.clock(clock), .nrst(nrst), .port(refresh_x.sync_side));

   // exit seen without link clock
   // The link clock may be stopped in self refresh, so the core clock watches
   // the gate pin and hands the exit back as a level until the link acts on it.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         self_refresh_exit <= 1'b0;
      end else begin
         self_refresh_exit <= refresh_x.q && gate_x.q;
      end
   end

   assign exit_x.d = self_refresh_exit;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         toggle_seen <= 1'b0;
      end else begin
         toggle_seen <= toggle_x.q;
      end
   end

   assign toggle_event = toggle_x.q != toggle_seen;

   // One core-clock pulse per delivered command.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= toggle_event;
      end
   end

   // Limitation: commands closer than two link clocks may overwrite the
   // held word before the core samples it; bank and mode state stay exact.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_code <= ddrca_pkg::CMD_NOP;
         cmd_bank <= '0;
         cmd_addr <= '0;
         cmd_auto_precharge <= 1'b0;
         cmd_all_banks <= 1'b0;
         cmd_burst_chop <= 1'b0;
      end else if (toggle_event) begin
         cmd_code <= held_cmd;
         cmd_bank <= held_bank;
         cmd_addr <= held_addr;
         cmd_auto_precharge <= held_ap;
         cmd_all_banks <= held_all;
         cmd_burst_chop <= held_chop;
      end
   end
endmodule
`default_nettype wire

/* verilog/ddrca_pkg.sv */
// Shared constants, types and decode helpers for the command and address pin logic.
package ddrca_pkg;

   // Default pin widths.
   localparam int ROW_BITS = 16;
   localparam int BANK_BITS = 3;

   // Mode configuration registers.
   localparam int MODE_REG_COUNT = 4;
   localparam int MODE_INDEX_BITS = 2;
   localparam logic [1:0] MODE_BURST_REG = 2'h0;
   localparam logic [1:0] MODE_TERM_REG = 2'h1;

   // Address bits with a meaning of their own.
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam int BURST_CHOP_BIT = 12;
   localparam int COLUMN_BITS = 10;

   // Burst field of the burst mode register.
   localparam int BURST_FIELD_LSB = 0;
   localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BURST_FIXED_FOUR = 2'h2;

   // Termination fields of the termination mode register.
   localparam int TERM_VALUE_BIT0 = 2;
   localparam int TERM_VALUE_BIT1 = 6;
   localparam int TERM_VALUE_BIT2 = 9;
   localparam int TERM_STROBE_BIT = 11;

   typedef enum logic [3:0] {
      CMD_NOP,
      CMD_DESELECT,
      CMD_LOAD_MODE,
      CMD_REFRESH,
      CMD_PRECHARGE,
      CMD_ACTIVATE,
      CMD_WRITE,
      CMD_READ,
      CMD_CALIBRATE
   } ddrca_cmd_t;

   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_PRECHARGE_DOWN,
      PWR_ACTIVE_DOWN,
      PWR_SELF_REFRESH
   } ddrca_pwr_t;

   // The four strobes together form the command code.
   function automatic ddrca_cmd_t decode(input logic cs_n, input logic ras_n, input logic cas_n,
                                         input logic we_n);
      ddrca_cmd_t c;
      c = CMD_NOP;
      if (cs_n) begin
         c = CMD_DESELECT;
      end else begin
         unique case ({ras_n, cas_n, we_n})
            3'h0: c = CMD_LOAD_MODE;
            3'h1: c = CMD_REFRESH;
            3'h2: c = CMD_PRECHARGE;
            3'h3: c = CMD_ACTIVATE;
            3'h4: c = CMD_WRITE;
            3'h5: c = CMD_READ;
            3'h6: c = CMD_CALIBRATE;
            3'h7: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

   // Burst chop from the burst field and the sampled chop pin.
   function automatic logic chop_of(input logic [1:0] field, input logic chop_n);
      logic r;
      r = 1'b0;
      if (field == BURST_ON_THE_FLY) begin
         r = ~chop_n;
      end else if (field == BURST_FIXED_FOUR) begin
         r = 1'b1;
      end
      return r;
   endfunction

endpackage

/* verilog/ddrca_sync_if.sv */
// Carrier for one bit crossing into a clock domain.
`timescale 1ns/1ns
`default_nettype none
interface ddrca_sync_if;
   logic d;
   logic q;
   modport sync_side (input d, output q);
   modport user_side (output d, input q);
endinterface
`default_nettype wire

/* verilog/ddrca_sync.sv */
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ns
`default_nettype none
module ddrca_sync (
   // Destination clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Crossing bit
   ddrca_sync_if.sync_side port
);
   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= port.d;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Waiting for agreement filters a single metastable resolution.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         port.q <= 1'b0;
      end else if (stage2 == stage3) begin
         port.q <= stage3;
      end
   end
endmodule
`default_nettype wire

/* verification/ddrca_chk.sv */
// Concurrent checks on the ports of the command and address pin logic.
`timescale 1ns/1ns
`default_nettype none
module ddrca_chk #(
   parameter int ROW_BITS = 16,
   parameter int BANK_BITS = 3
) (
   // Clocks and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic cmd_clock,
   // Pins
   input wire logic chip_select_n,
   input wire logic termination_enable,
   input wire logic write_mask,
   input wire logic write_beat_valid,
   // Status and delivery
   input wire ddrca_pkg::ddrca_pwr_t power_state,
   input wire logic [(1<<BANK_BITS)-1:0] banks_open,
   input wire logic termination_on,
   input wire logic termination_data_strobe_on,
   input wire logic write_beat_keep,
   input wire logic cmd_valid,
   input wire ddrca_pkg::ddrca_cmd_t cmd_code,
   input wire logic [ROW_BITS-1:0] cmd_addr,
   input wire logic cmd_auto_precharge,
   input wire logic cmd_all_banks
);
   wire logic rw = cmd_valid && cmd_code inside {ddrca_pkg::CMD_READ, ddrca_pkg::CMD_WRITE};
   wire logic sr = power_state == ddrca_pkg::PWR_SELF_REFRESH;
   sequence s_masked_beat;
      write_beat_valid && write_mask && power_state == ddrca_pkg::PWR_ACTIVE;
   endsequence
   AST_COLUMN_WIDTH: assert property (@(posedge clock) disable iff (!nrst)
      rw |-> cmd_addr[ROW_BITS-1:ddrca_pkg::COLUMN_BITS] == '0) else $error("Column address too wide.");
   AST_AP_SCOPE: assert property (@(posedge clock) disable iff (!nrst)
      cmd_valid && !rw |-> !cmd_auto_precharge) else $error("Auto-precharge outside read or write.");
   AST_ALL_SCOPE: assert property (@(posedge clock) disable iff (!nrst)
      cmd_valid && cmd_code != ddrca_pkg::CMD_PRECHARGE |-> !cmd_all_banks) else $error("All-bank flag misused.");
   AST_DESELECT: assert property (@(posedge cmd_clock) disable iff (!nrst)
      chip_select_n |=> ##1 $stable(banks_open)) else $error("Deselected command changed banks.");
   AST_PD_IDLE: assert property (@(posedge cmd_clock) disable iff (!nrst)
      power_state == ddrca_pkg::PWR_PRECHARGE_DOWN |-> banks_open == '0) else $error("Precharge down with open bank.");
   AST_APD_OPEN: assert property (@(posedge cmd_clock) disable iff (!nrst)
      power_state == ddrca_pkg::PWR_ACTIVE_DOWN |-> banks_open != '0) else $error("Active down with no open bank.");
   AST_SR_NO_TERM: assert property (@(posedge cmd_clock) disable iff (!nrst)
      sr && $past(sr) |-> !termination_on) else $error("Termination on in self refresh.");
   AST_TERM_CAUSE: assert property (@(posedge cmd_clock) disable iff (!nrst)
      $rose(termination_on) |-> $past(termination_enable, 2)) else $error("Termination rose without enable.");
   AST_MASK_DROP: assert property (@(posedge cmd_clock) disable iff (!nrst)
      s_masked_beat ##0 !termination_data_strobe_on |=> ##1 !write_beat_keep) else $error("Masked beat kept.");
   AST_STROBE_KEEP: assert property (@(posedge cmd_clock) disable iff (!nrst)
      s_masked_beat ##0 termination_data_strobe_on |=> ##1 write_beat_keep) else $error("Mask active with strobe.");
endmodule
bind ddrca_top ddrca_chk #(.ROW_BITS(ROW_BITS), .BANK_BITS(BANK_BITS)) u_chk (
   .clock(clock), .nrst(nrst), .cmd_clock(cmd_clock), .chip_select_n(chip_select_n),
   .termination_enable(termination_enable), .write_mask(write_mask), .write_beat_valid(write_beat_valid),
   .power_state(power_state), .banks_open(banks_open), .termination_on(termination_on),
   .termination_data_strobe_on(termination_data_strobe_on), .write_beat_keep(write_beat_keep),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
   .cmd_auto_precharge(cmd_auto_precharge), .cmd_all_banks(cmd_all_banks));
`default_nettype wire

/* verification/ddrca_ctrl_model.sv */
// Behavioural memory controller driving the command, address and control pins.
`timescale 1ns/1ns
`default_nettype none
module ddrca_ctrl_model (
   // Link clock
   input wire logic cmd_clock,
   // Command pins
   output logic chip_select_n,
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic write_enable_n,
   output logic [15:0] address,
   output logic [2:0] bank_select,
   // Control pins
   output logic clock_gate,
   output logic termination_enable,
   output logic write_mask,
   output logic write_beat_valid
);
   // Gate starts high so the first sampled edge does not enter power-down.
   initial begin
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hf;
      address = 16'h0000;
      bank_select = 3'h0;
      clock_gate = 1'b1;
      termination_enable = 1'b0;
      write_mask = 1'b0;
      write_beat_valid = 1'b0;
   end
   task automatic send(input logic cs_n, input logic g, input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [15:0] a);
      @(negedge cmd_clock);
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = {cs_n, rcw};
      clock_gate = g;
      bank_select = ba;
      address = a;
      @(negedge cmd_clock);
      // Released lines flip so a stale value can never pass for a held one.
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = {1'b1, ~rcw};
      bank_select = ~ba;
      address = ~a;
      @(posedge cmd_clock);
      #1;
   endtask
   task automatic beat(input logic m);
      @(negedge cmd_clock);
      write_beat_valid = 1'b1;
      write_mask = m;
      @(negedge cmd_clock);
      write_beat_valid = 1'b0;
      write_mask = ~m;
      @(posedge cmd_clock);
      #1;
   endtask
   task automatic level(input logic g, input logic t);
      @(negedge cmd_clock);
      clock_gate = g;
      termination_enable = t;
      @(posedge cmd_clock);
      @(posedge cmd_clock);
      #1;
   endtask
endmodule
`default_nettype wire

/* verification/ddrca_top_test.sv */
// Self-checking bench for the command and address pin logic.
`timescale 1ns/1ns
`default_nettype none
module ddrca_top_test;
   logic clock = 1'b0;
   logic cmd_clock = 1'b0;
   logic nrst = 1'b0;
   wire logic cs_n, ras_n, cas_n, we_n, gate, term, mask, beat_v;
   wire logic [15:0] addr;
   wire logic [2:0] ba;
   wire ddrca_pkg::ddrca_pwr_t pwr;
   wire logic [7:0] banks;
   wire logic term_on, strobe_on, keep, cmd_valid, ap, all_banks, chop, sr_exit;
   wire ddrca_pkg::ddrca_cmd_t cmd_code;
   wire logic [2:0] cmd_bank;
   wire logic [15:0] cmd_addr;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   always #4 clock = ~clock;
   initial begin
      #3;
      forever #16 cmd_clock = ~cmd_clock;
   end
   ddrca_top dut (
      .clock(clock), .nrst(nrst), .cmd_clock(cmd_clock), .chip_select_n(cs_n), .row_strobe_n(ras_n),
      .column_strobe_n(cas_n), .write_enable_n(we_n), .address(addr), .bank_select(ba),
      .clock_gate(gate), .termination_enable(term), .write_mask(mask), .write_beat_valid(beat_v),
      .power_state(pwr), .banks_open(banks), .termination_on(term_on), .termination_data_strobe_on(strobe_on),
      .write_beat_keep(keep), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
      .cmd_addr(cmd_addr), .cmd_auto_precharge(ap), .cmd_all_banks(all_banks), .cmd_burst_chop(chop),
      .self_refresh_exit(sr_exit));
   ddrca_ctrl_model ctrl (
      .cmd_clock(cmd_clock), .chip_select_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
      .write_enable_n(we_n), .address(addr), .bank_select(ba), .clock_gate(gate),
      .termination_enable(term), .write_mask(mask), .write_beat_valid(beat_v));
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic take_cmd(input ddrca_pkg::ddrca_cmd_t c, input logic [2:0] b, input logic [15:0] a,
                           input logic [2:0] f);
      int n;
      n = 0;
      while (cmd_valid !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      compare(16'(cmd_valid), 16'h0001);
      compare(16'(cmd_code), 16'(c));
      compare(16'(cmd_bank), 16'(b));
      compare(cmd_addr, a);
      compare(16'({ap, all_banks, chop}), 16'(f));
      @(negedge clock);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic test_reset;
      compare(16'(pwr), 16'(ddrca_pkg::PWR_ACTIVE));
      compare(16'(banks), 16'h0000);
      compare(16'({term_on, strobe_on, keep, cmd_valid}), 16'h0000);
      $display("test reset finished");
   endtask
   task automatic test_access;
      ctrl.send(0, 1, 3'h3, 3'h2, 16'h1234);
      compare(16'(banks), 16'h0004);
      take_cmd(ddrca_pkg::CMD_ACTIVATE, 3'h2, 16'h1234, 3'h0);
      ctrl.send(0, 1, 3'h0, 3'h0, 16'h0002);
      take_cmd(ddrca_pkg::CMD_LOAD_MODE, 3'h0, 16'h0002, 3'h0);
      ctrl.send(0, 1, 3'h5, 3'h2, 16'h1000);
      take_cmd(ddrca_pkg::CMD_READ, 3'h2, 16'h0000, 3'h1);
      ctrl.send(0, 1, 3'h0, 3'h0, 16'h0001);
      ctrl.send(0, 1, 3'h4, 3'h2, 16'h1123);
      take_cmd(ddrca_pkg::CMD_WRITE, 3'h2, 16'h0123, 3'h0);
      ctrl.send(0, 1, 3'h5, 3'h2, 16'he5a5);
      take_cmd(ddrca_pkg::CMD_READ, 3'h2, 16'h01a5, 3'h5);
      compare(16'(banks), 16'h0000);
      $display("test access finished");
   endtask
   task automatic test_precharge;
      ctrl.send(0, 1, 3'h3, 3'h1, 16'h0000);
      ctrl.send(0, 1, 3'h3, 3'h5, 16'h0000);
      compare(16'(banks), 16'h0022);
      ctrl.send(1, 1, 3'h2, 3'h5, 16'h0400);
      compare(16'(banks), 16'h0022);
      ctrl.send(0, 1, 3'h2, 3'h1, 16'h0000);
      compare(16'(banks), 16'h0020);
      ctrl.send(0, 1, 3'h2, 3'h0, 16'h0400);
      compare(16'(banks), 16'h0000);
      take_cmd(ddrca_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, 3'h2);
      $display("test precharge finished");
   endtask
   task automatic test_termination;
      ctrl.level(1, 1);
      compare(16'(term_on), 16'h0000);
      ctrl.send(0, 1, 3'h0, 3'h1, 16'h0004);
      ctrl.level(1, 1);
      compare(16'(term_on), 16'h0001);
      ctrl.send(0, 1, 3'h0, 3'h4, 16'h0000);
      ctrl.level(1, 1);
      compare(16'(term_on), 16'h0001);
      ctrl.level(1, 0);
      compare(16'(term_on), 16'h0000);
      ctrl.level(1, 1);
      ctrl.beat(0);
      compare(16'(keep), 16'h0001);
      ctrl.beat(1);
      compare(16'(keep), 16'h0000);
      ctrl.send(0, 1, 3'h0, 3'h1, 16'h0804);
      ctrl.level(1, 1);
      compare(16'(strobe_on), 16'h0001);
      ctrl.beat(1);
      compare(16'(keep), 16'h0001);
      $display("test termination and mask finished");
   endtask
   task automatic test_power;
      logic seen;
      int n;
      seen = 1'b0;
      ctrl.level(0, 1);
      compare(16'(pwr), 16'(ddrca_pkg::PWR_PRECHARGE_DOWN));
      ctrl.send(0, 0, 3'h3, 3'h3, 16'h0000);
      compare(16'(banks), 16'h0000);
      ctrl.level(1, 1);
      compare(16'(pwr), 16'(ddrca_pkg::PWR_ACTIVE));
      ctrl.send(0, 1, 3'h3, 3'h3, 16'h0000);
      ctrl.level(0, 1);
      compare(16'(pwr), 16'(ddrca_pkg::PWR_ACTIVE_DOWN));
      ctrl.level(1, 1);
      ctrl.send(0, 1, 3'h2, 3'h0, 16'h0400);
      ctrl.send(0, 0, 3'h1, 3'h0, 16'h0000);
      compare(16'(pwr), 16'(ddrca_pkg::PWR_SELF_REFRESH));
      @(posedge cmd_clock);
      #1;
      compare(16'(term_on), 16'h0000);
      ctrl.level(1, 1);
      for (n = 0; n < 200 && pwr !== ddrca_pkg::PWR_ACTIVE; n++) begin
         seen = seen | (sr_exit === 1'b1);
         @(negedge clock);
      end
      compare(16'(seen), 16'h0001);
      compare(16'(pwr), 16'(ddrca_pkg::PWR_ACTIVE));
      $display("test power finished");
   endtask
   task automatic test_async_reset;
      ctrl.send(0, 1, 3'h3, 3'h7, 16'h0000);
      compare(16'(banks), 16'h0080);
      @(negedge clock);
      nrst = 1'b0;
      #1;
      compare(16'(banks), 16'h0000);
      repeat (8) @(negedge clock);
      nrst = 1'b1;
      $display("test async reset finished");
   endtask
   initial begin
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      test_reset();
      test_access();
      test_precharge();
      test_termination();
      test_power();
      test_async_reset();
      test_reset();
      end_of_test();
   end
endmodule
`default_nettype wire
